// ==== src/aics_map.svh ====
// Constants for the analog input channel scanner
`ifndef AICS_MAP_SVH
`define AICS_MAP_SVH

`define AICS_GROUP_BITS 32
`define AICS_CHAN_COUNT 4'h8
`define AICS_CHAN_FIRST 3'h0
`define AICS_CHAN_LAST 3'h7
`define AICS_BASE_MAX 11'h400
`define AICS_FLD_CHAN_LO 0
`define AICS_FLD_VALID 8
`define AICS_FLD_OPEN 10
`define AICS_FLD_SIGN 11
`define AICS_FLD_BOARD_OK 12
`define AICS_FLD_UNDER 13
`define AICS_FLD_OVER 14
`define AICS_FLD_HEARTBEAT 15
`define AICS_FLD_DATA_LO 16
`define AICS_ADC_BITS 12

`endif

// ==== src/aics_pkg.sv ====
// Types for the analog input channel scanner
package aics_pkg;

    // One finished conversion of one channel
    typedef struct packed {
        logic [2:0] chan;
        logic [11:0] data;
        logic sign;
        logic open_wire;
        logic under;
        logic over;
    } aics_conv_t;

    // Word presented on the 32 shared input points, bit 0 is input 1
    typedef logic [31:0] aics_word_t;

    typedef enum logic [1:0] {
        AICS_IDLE,
        AICS_CONV,
        AICS_PUSH
    } aics_state_t;

endpackage

// ==== src/aics_buf2.sv ====
// Two-entry buffer between the conversion result and the host input word
`timescale 1ns/1ps
module aics_buf2 (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire aics_pkg::aics_word_t in_word,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output aics_pkg::aics_word_t out_word
);
    aics_pkg::aics_word_t mem_q [0:1];
    logic wr_q;
    logic rd_q;
    logic [1:0] cnt_q;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = (cnt_q != 2'h2);
    assign out_valid = (cnt_q != 2'h0);
    assign out_word = mem_q[rd_q];

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            cnt_q <= 2'h0;
            mem_q[0] <= '0;
            mem_q[1] <= '0;
        end else begin
            if (push) begin
                mem_q[wr_q] <= in_word;
                wr_q <= ~wr_q;
            end
            if (pop) begin
                rd_q <= ~rd_q;
            end
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_buf_no_overflow;
        @(posedge clk_sys) disable iff (srst)
            (cnt_q == 2'h2 && !out_ready) |=> (cnt_q == 2'h2) && $stable(out_word);
    endproperty
    a_buf_no_overflow: assert property (p_buf_no_overflow) else $error("full buffer changed");

    property p_buf_fill;
        @(posedge clk_sys) disable iff (srst)
            (push && !pop && cnt_q == 2'h0) |=> out_valid;
    endproperty
    a_buf_fill: assert property (p_buf_fill) else $error("pushed word not visible");

    c_buf_full: cover property (@(posedge clk_sys) disable iff (srst) cnt_q == 2'h2);
endmodule

// ==== src/aics_scanner.sv ====
// Channel sequencer and input-group addressing of the eight-channel analog input
// Summary of operation
// - Module occupies one 32-bit input group
// - Switches 7..3 select group, open reads one
// - All channels share the same group
// - One channel converted per host scan
// - Next scan advances channel by one
// - Wrap to first channel after last
// - Host-directed transfers served as scans
// - Channel number 1 to 8 in low byte
// - Heartbeat toggles per completed reading
`timescale 1ns/1ps
`include "aics_map.svh"
module aics_scanner (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Backplane switches, closed is low, index 0 is switch 1
    input wire logic [6:0] dip_sw,
    // Host scan requests, both pulses on clk_sys
    input wire logic io_scan,
    input wire logic do_io,
    // Converter side
    output logic conv_start,
    output logic [2:0] conv_chan,
    input wire logic conv_done,
    input wire aics_pkg::aics_conv_t conv_res,
    // Board health
    input wire logic supply_ok,
    input wire logic board_ok,
    // Host input group
    output logic [10:0] group_base,
    output logic group_cfg_err,
    output logic word_valid,
    input wire logic word_ready,
    output aics_pkg::aics_word_t word_data
);
    // ------------------------------------------------------------
    // Switch synchroniser and group decode
    // ------------------------------------------------------------
    logic [6:0] sw_meta_q;
    logic [6:0] sw_q;
    logic [10:0] base_q;
    logic cfg_err_q;

    function automatic logic [10:0] base_of(input logic [4:0] idx);
        base_of = {1'b0, idx, 5'h00} + 11'h001;
    endfunction

    wire [10:0] base_d = base_of(sw_q[6:2]);
    wire cfg_err_d = sw_q[0] | sw_q[1];

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sw_meta_q <= 7'h00;
            sw_q <= 7'h00;
            base_q <= 11'h001;
            cfg_err_q <= 1'b0;
        end else begin
            sw_meta_q <= dip_sw;
            sw_q <= sw_meta_q;
            base_q <= base_d;
            cfg_err_q <= cfg_err_d;
        end
    end
    assign group_base = base_q;
    assign group_cfg_err = cfg_err_q;

    // ------------------------------------------------------------
    // Channel sequencer
    // ------------------------------------------------------------
    aics_pkg::aics_state_t state_q;
    aics_pkg::aics_state_t state_d;
    logic [2:0] chan_q;
    logic [2:0] chan_d;
    logic hb_q;
    aics_pkg::aics_word_t res_q;
    logic buf_ready;
    wire scan_req = io_scan | do_io;
    wire start_ok = (state_q == aics_pkg::AICS_IDLE) && scan_req;
    wire push_ok = (state_q == aics_pkg::AICS_PUSH) && buf_ready;
    wire [2:0] chan_next = (chan_q == `AICS_CHAN_LAST) ? `AICS_CHAN_FIRST : chan_q + 3'h1;

    function automatic aics_pkg::aics_word_t pack_word(input aics_pkg::aics_conv_t r,
                                                        input logic [2:0] ch,
                                                        input logic hb,
                                                        input logic sup,
                                                        input logic ok);
        aics_pkg::aics_word_t w;
        w = '0;
        // Eight-bit sum so that the last channel reads as 8, not 0
        w[`AICS_FLD_CHAN_LO +: 8] = {5'h00, ch} + 8'h01;
        w[`AICS_FLD_VALID] = ok;
        w[`AICS_FLD_OPEN] = r.open_wire;
        w[`AICS_FLD_SIGN] = r.sign;
        w[`AICS_FLD_BOARD_OK] = sup;
        w[`AICS_FLD_UNDER] = r.under;
        w[`AICS_FLD_OVER] = r.over;
        w[`AICS_FLD_HEARTBEAT] = hb;
        w[27:16] = r.data;
        w[31:28] = {4{r.sign}};
        pack_word = w;
    endfunction

    always_comb begin
        state_d = state_q;
        chan_d = chan_q;
        unique case (state_q)
            aics_pkg::AICS_IDLE: begin
                if (scan_req) begin
                    state_d = aics_pkg::AICS_CONV;
                end
            end
            aics_pkg::AICS_CONV: begin
                if (conv_done) begin
                    state_d = aics_pkg::AICS_PUSH;
                end
            end
            aics_pkg::AICS_PUSH: begin
                if (buf_ready) begin
                    state_d = aics_pkg::AICS_IDLE;
                    chan_d = chan_next;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state_q <= aics_pkg::AICS_IDLE;
            chan_q <= `AICS_CHAN_FIRST;
            hb_q <= 1'b0;
            res_q <= '0;
        end else begin
            state_q <= state_d;
            chan_q <= chan_d;
            if (state_q == aics_pkg::AICS_CONV && conv_done) begin
                hb_q <= ~hb_q;
                res_q <= pack_word(conv_res, chan_q, ~hb_q, supply_ok, board_ok);
            end
        end
    end

    assign conv_start = start_ok;
    assign conv_chan = chan_q;

    // ------------------------------------------------------------
    // Shared input group buffer
    // ------------------------------------------------------------
    aics_buf2 u_buf (
        .clk_sys(clk_sys),
        .srst(srst),
        .in_valid(state_q == aics_pkg::AICS_PUSH),
        .in_ready(buf_ready),
        .in_word(res_q),
        .out_valid(word_valid),
        .out_ready(word_ready),
        .out_word(word_data)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_advance;
        @(posedge clk_sys) disable iff (srst)
            (push_ok && chan_q != `AICS_CHAN_LAST) |=> (chan_q == $past(chan_q) + 3'h1);
    endproperty
    a_advance: assert property (p_advance) else $error("channel did not advance");

    property p_wrap;
        @(posedge clk_sys) disable iff (srst)
            (push_ok && chan_q == `AICS_CHAN_LAST) |=> (chan_q == `AICS_CHAN_FIRST);
    endproperty
    a_wrap: assert property (p_wrap) else $error("channel did not wrap");

    property p_one_per_scan;
        @(posedge clk_sys) disable iff (srst)
            conv_start |=> (state_q == aics_pkg::AICS_CONV) && !conv_start;
    endproperty
    a_one_per_scan: assert property (p_one_per_scan) else $error("second start in scan");

    property p_scan_starts;
        @(posedge clk_sys) disable iff (srst)
            (state_q == aics_pkg::AICS_IDLE && scan_req)
                |-> conv_start ##1 (state_q == aics_pkg::AICS_CONV);
    endproperty
    a_scan_starts: assert property (p_scan_starts) else $error("scan not served");

    property p_chan_field;
        @(posedge clk_sys) disable iff (srst)
            (state_q == aics_pkg::AICS_CONV && conv_done)
                |=> (res_q[7:0] == {5'h00, chan_q} + 8'h01);
    endproperty
    a_chan_field: assert property (p_chan_field) else $error("channel field wrong");

    // Channel must not move while a conversion is in flight
    property p_chan_hold;
        @(posedge clk_sys) disable iff (srst)
            (state_q == aics_pkg::AICS_CONV) |=> $stable(chan_q);
    endproperty
    a_chan_hold: assert property (p_chan_hold) else $error("channel moved mid scan");

    property p_heartbeat;
        @(posedge clk_sys) disable iff (srst)
            (state_q == aics_pkg::AICS_CONV && conv_done) |=> (hb_q != $past(hb_q));
    endproperty
    a_heartbeat: assert property (p_heartbeat) else $error("heartbeat missed");

    property p_base;
        @(posedge clk_sys) disable iff (srst)
            ##2 (group_base == {1'b0, $past(sw_q[6:2]), 5'h00} + 11'h001)
                && group_base <= `AICS_BASE_MAX;
    endproperty
    a_base: assert property (p_base) else $error("group base wrong");

    property p_reset_chan;
        @(posedge clk_sys) srst |=> (chan_q == `AICS_CHAN_FIRST);
    endproperty
    a_reset_chan: assert property (p_reset_chan) else $error("reset channel wrong");

    c_wrap: cover property (@(posedge clk_sys) disable iff (srst)
        push_ok && chan_q == `AICS_CHAN_LAST);
    c_stall: cover property (@(posedge clk_sys) disable iff (srst)
        word_valid && !word_ready && !buf_ready);
    c_do_io: cover property (@(posedge clk_sys) disable iff (srst) do_io && start_ok);
endmodule

// ==== verif/aics_conv_model.sv ====
// Behavioural converter answering the scanner's conversion requests
`timescale 1ns/1ps
module aics_conv_model (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Request and bench controls
    input wire logic conv_start,
    input wire logic [2:0] conv_chan,
    input wire logic [3:0] lat,
    input wire logic neg,
    // Answer
    output logic conv_done,
    output aics_pkg::aics_conv_t conv_res
);
    logic [3:0] cnt_q;
    logic busy_q;
    aics_pkg::aics_conv_t res;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            busy_q <= 1'b0;
        end else if (conv_start) begin
            busy_q <= 1'b1;
        end else if (conv_done) begin
            busy_q <= 1'b0;
        end
        cnt_q <= conv_start ? lat : cnt_q - 4'h1;
    end

    assign conv_done = busy_q && cnt_q == 4'h0;
    assign res = '{chan: conv_chan, data: {9'h0b4, conv_chan}, sign: neg,
        open_wire: conv_chan[0], under: conv_chan[1], over: conv_chan[2]};
    // Result is only meaningful in the done cycle
    assign conv_res = conv_done ? res : ~res;
endmodule

// ==== verif/aics_scanner_tb_top.sv ====
// Self-checking bench for the analog input channel scanner
`timescale 1ns/1ps
module aics_scanner_tb_top;
    logic clk_sys = 0;
    logic srst = 1;
    logic [6:0] dip_sw = 7'h00;
    logic io_scan = 0, do_io = 0, word_ready = 0;
    logic supply_ok = 1, board_ok = 1, neg = 0, hb = 0;
    logic conv_start, conv_done, word_valid, group_cfg_err;
    logic [3:0] lat = 4'h2;
    logic [2:0] conv_chan, ch_e = 3'h0, rq_e = 3'h0;
    logic [10:0] group_base;
    aics_pkg::aics_conv_t conv_res;
    aics_pkg::aics_word_t word_data;
    int failures = 0, compares = 0, cycles = 0;

    initial begin
        forever #2 clk_sys = ~clk_sys;
    end

    aics_scanner DUT (.clk_sys(clk_sys), .srst(srst), .dip_sw(dip_sw), .io_scan(io_scan),
        .do_io(do_io), .conv_start(conv_start), .conv_chan(conv_chan), .conv_done(conv_done),
        .conv_res(conv_res), .supply_ok(supply_ok), .board_ok(board_ok),
        .group_base(group_base), .group_cfg_err(group_cfg_err), .word_valid(word_valid),
        .word_ready(word_ready), .word_data(word_data));
    aics_conv_model conv (.clk_sys(clk_sys), .srst(srst), .conv_start(conv_start),
        .conv_chan(conv_chan), .lat(lat), .neg(neg), .conv_done(conv_done),
        .conv_res(conv_res));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic final_report();
        if (failures == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            final_report();
        end
    end

    // Hold the request until the scanner takes it
    task automatic req(input logic dio);
        int n;
        n = 0;
        @(posedge clk_sys) #1;
        io_scan = !dio;
        do_io = dio;
        #2;
        while (conv_start !== 1'b1 && n < 40) begin
            @(posedge clk_sys) #2;
            n++;
        end
        check("scan taken", {31'h0, conv_start}, 32'h1);
        check("conv chan", {29'h0, conv_chan}, {29'h0, rq_e});
        rq_e = rq_e + 3'h1;
        @(posedge clk_sys) #1;
        io_scan = 0;
        do_io = 0;
    endtask

    task automatic take();
        int n;
        logic [7:0] cn;
        logic [31:0] exp;
        n = 0;
        #1;
        while (word_valid !== 1'b1 && n < 40) begin
            @(posedge clk_sys) #2;
            n++;
        end
        hb = ~hb;
        cn = {5'h00, ch_e} + 8'h01;
        exp = {{4{neg}}, 9'h0b4, ch_e, hb, ch_e[2], ch_e[1], supply_ok, neg, ch_e[0], 1'b0,
            board_ok, cn};
        check("word", word_data, exp);
        ch_e = ch_e + 3'h1;
        @(posedge clk_sys) #1;
        word_ready = 1;
        @(posedge clk_sys) #1;
        word_ready = 0;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        repeat (4) @(posedge clk_sys) #1;
        check("base", {21'h0, group_base}, 32'h1);
        check("valid", {31'h0, word_valid}, 32'h0);
    endtask

    task automatic t_group();
        logic [4:0] idx [4] = '{5'h00, 5'h01, 5'h15, 5'h1f};
        for (int i = 0; i < 4; i++) begin
            dip_sw = {idx[i], 2'b00};
            repeat (4) @(posedge clk_sys) #1;
            check("base", {21'h0, group_base}, {22'h0, idx[i], 5'h01});
            check("cfg err", {31'h0, group_cfg_err}, 32'h0);
        end
        for (int i = 1; i < 3; i++) begin
            dip_sw = {5'h00, 2'(i)};
            repeat (4) @(posedge clk_sys) #1;
            check("cfg err", {31'h0, group_cfg_err}, 32'h1);
        end
        dip_sw = 7'h00;
        repeat (4) @(posedge clk_sys) #1;
    endtask

    task automatic t_sweep();
        for (int i = 0; i < 10; i++) begin
            board_ok = i[0];
            supply_ok = i[1];
            neg = i[2];
            lat = 4'(i % 3);
            req(i[0]);
            take();
        end
    endtask

    // Host stalls: two words buffered, third conversion waits for room
    task automatic t_stall();
        lat = 4'h0;
        req(1'b0);
        req(1'b1);
        req(1'b0);
        repeat (6) @(posedge clk_sys) #1;
        for (int i = 0; i < 3; i++) begin
            take();
        end
        repeat (6) @(posedge clk_sys) #1;
        check("drained", {31'h0, word_valid}, 32'h0);
    endtask

    initial begin
        repeat (5) @(posedge clk_sys);
        #1;
        srst = 0;
        t_reset();
        t_group();
        t_sweep();
        t_stall();
        final_report();
    end
endmodule
